/* rtl/eeprom_host_pkg.sv */
// Purpose: shared constants and types for the EEPROM module host controller
// Assumes: 40 MHz ref_clk_i, 15-bit word address, up to 32-bit data
// Notes: command addresses are parameters because their values are not fixed here
package eeprom_host_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LANES = 4;
  // Strobe timing, ns as printed, cycles derived (minimums round up)
  localparam int unsigned T_WP_NS = 100;
  localparam int unsigned T_WPH_NS = 50;
  localparam int unsigned T_AH_NS = 50;
  localparam int unsigned WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WPH_CYC = (T_WPH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned AH_CYC = (T_AH_NS * CLK_MHZ + 999) / 1000;
  // Load-to-load window, longest time rounds down
  localparam int unsigned T_BLC_US = 150;
  localparam int unsigned BLC_CYC = T_BLC_US * CLK_MHZ;
  // Chip erase: setup/hold 5 us, pulse 10 ms minimum
  localparam int unsigned T_ERS_SH_US = 5;
  localparam int unsigned T_ERASE_MS = 10;
  localparam int unsigned ERS_SH_CYC = T_ERS_SH_US * CLK_MHZ;
  localparam int unsigned ERASE_CYC = T_ERASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned WRITE_CYC = T_ERASE_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned PAGE_WORDS = 64;
  localparam logic [ADDR_W-1:0] ID_BASE = 15'h7fc0;
  localparam logic [7:0] CMD_AA = 8'haa;
  localparam logic [7:0] CMD_55 = 8'h55;
  localparam logic [7:0] CMD_A0 = 8'ha0;
  localparam logic [7:0] CMD_80 = 8'h80;
  localparam logic [7:0] CMD_20 = 8'h20;
  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_PROT_WRITE,
    OP_UNPROTECT,
    OP_ERASE,
    OP_ID_READ,
    OP_ID_WRITE
  } op_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } word_t;
  typedef struct packed {
    logic [LANES-1:0] lane_select_n;
    logic [LANES-1:0] lane_write_strobe_n;
    logic out_gate_n;
    logic out_gate_hv;
    logic id_access_hv;
  } pins_t;
endpackage

/* rtl/strobe_timer.sv */
// Purpose: down-counter that times each strobe phase
// Assumes: load and count come from the same clock domain
// Notes: done is high when the counter is zero
`timescale 1ns/1ps
module strobe_timer #(
  parameter int unsigned W = 20
) (
  input wire logic ref_clk_i, // clock
  input wire logic reset_i, // sync reset
  input wire logic load_i, // load a new count
  input wire logic [W-1:0] value_i, // count to load
  output logic done_o // counter at zero
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  always_comb begin
    cnt_next = cnt_reg;
    if (load_i) begin
      cnt_next = value_i;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign done_o = (cnt_reg == '0);
endmodule

/* rtl/eeprom_host.sv */
// Purpose: host controller driving the EEPROM module pins for read, write, erase
// Assumes: one request at a time; command bytes are replicated on all active lanes
// Notes: no clock inside the device; all timing comes from ref_clk_i counts; protection lives only in the part
// Operation
// - ID area: top 64 addresses with flag
// - Gate HV with select/strobe low erases
// - Protected writes need three-load prefix each time
// - Six-load sequence turns protection off
// - Replicate command byte on all active lanes
// - Command loads use page-write load timing
// - One to 64 words follow prefix
// - Next load within 150 us of previous; host does not time it, each word waits for word_valid_i
`timescale 1ns/1ps
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter logic [eeprom_host_pkg::ADDR_W-1:0] CMD_ADDR_A = 15'h5555,
  parameter logic [eeprom_host_pkg::ADDR_W-1:0] CMD_ADDR_B = 15'h2aaa,
  parameter int unsigned ERASE_CYCLES = eeprom_host_pkg::ERASE_CYC,
  parameter int unsigned WRITE_CYCLES = eeprom_host_pkg::WRITE_CYC
) (
  input wire logic ref_clk_i, // clock
  input wire logic reset_i, // sync reset, active high
  input wire logic req_valid_i, // start operation
  input wire eeprom_host_pkg::op_t req_op_i, // operation
  input wire logic [eeprom_host_pkg::LANES-1:0] lanes_i, // active byte lanes
  input wire logic [6:0] req_count_i, // words in page, 1..64
  output logic req_ready_o, // idle, request accepted
  input wire logic word_valid_i, // page word offered
  input wire eeprom_host_pkg::word_t word_i, // page word
  output logic word_ready_o, // page word taken
  output logic rd_valid_o, // read data pulse
  output logic [eeprom_host_pkg::DATA_W-1:0] rd_data_o, // read data
  output logic [eeprom_host_pkg::ADDR_W-1:0] addr_o, // address pins
  output logic [eeprom_host_pkg::DATA_W-1:0] dq_o, // data pins out
  output logic dq_oe_o, // data pins driven
  input wire logic [eeprom_host_pkg::DATA_W-1:0] dq_i, // data pins in
  output eeprom_host_pkg::pins_t pins_o // control pins
);
  import eeprom_host_pkg::*;
  typedef enum logic [3:0] {
    S_IDLE, S_CMD_SETUP, S_CMD_LOW, S_CMD_HIGH, S_WAIT_WORD,
    S_DAT_LOW, S_DAT_HIGH, S_PROGRAM, S_RD_LOW, S_RD_SAMPLE,
    S_ERS_SETUP, S_ERS_PULSE, S_ERS_HOLD
  } state_t;
  state_t state_reg, state_next;
  op_t op_reg, op_next;
  logic [LANES-1:0] lanes_reg, lanes_next;
  logic [6:0] left_reg, left_next;
  logic [2:0] cmd_reg, cmd_next;
  logic [2:0] cmd_last_reg, cmd_last_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] dq_reg, dq_next, rd_reg, rd_next;
  logic dq_oe_reg, dq_oe_next, rd_valid_reg, rd_valid_next, ready_reg, ready_next, wready_reg, wready_next;
  pins_t pins_reg, pins_next;
  word_t cmd_w;
  logic [DATA_W-1:0] dq_s1_reg, dq_s2_reg;
  logic tload;
  logic [CNT_W-1:0] tval;
  logic tdone;

  // Command load table: up to six address/data pairs
  function automatic word_t cmd_word(input logic [2:0] idx, input logic unprot, input logic [LANES-1:0] ln);
    logic [7:0] b;
    logic [ADDR_W-1:0] a;
    word_t w;
    case (idx)
      3'h1: begin b = CMD_55; a = CMD_ADDR_B; end
      3'h2: begin b = unprot ? CMD_80 : CMD_A0; a = CMD_ADDR_A; end
      3'h4: begin b = CMD_55; a = CMD_ADDR_B; end
      3'h5: begin b = CMD_20; a = CMD_ADDR_A; end
      default: begin b = CMD_AA; a = CMD_ADDR_A; end
    endcase
    w.addr = a;
    w.data = lane_fill(b, ln);
    return w;
  endfunction
  function automatic logic [DATA_W-1:0] lane_fill(input logic [7:0] b, input logic [LANES-1:0] ln);
    logic [DATA_W-1:0] d;
    d = '0;
    for (int i = 0; i < LANES; i++) begin
      if (ln[i]) d[i*8 +: 8] = b;
    end
    return d;
  endfunction
  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    return CNT_W'(n);
  endfunction
  strobe_timer #(.W(CNT_W)) u_timer (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .load_i(tload),
    .value_i(tval),
    .done_o(tdone)
  );
  assign cmd_w = cmd_word(cmd_reg, op_reg == OP_UNPROTECT, lanes_reg);

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    lanes_next = lanes_reg;
    left_next = left_reg;
    cmd_next = cmd_reg;
    cmd_last_next = cmd_last_reg;
    addr_next = addr_reg;
    dq_next = dq_reg;
    dq_oe_next = dq_oe_reg;
    rd_next = rd_reg;
    rd_valid_next = 1'b0;
    ready_next = 1'b0;
    wready_next = 1'b0;
    pins_next = pins_reg;
    tload = 1'b0;
    tval = '0;
    case (state_reg)
      S_IDLE: begin
        ready_next = 1'b1;
        pins_next.lane_select_n = '1;
        pins_next.lane_write_strobe_n = '1;
        pins_next.out_gate_n = 1'b1;
        pins_next.out_gate_hv = 1'b0;
        pins_next.id_access_hv = 1'b0;
        dq_oe_next = 1'b0;
        if (req_valid_i && ready_reg) begin
          ready_next = 1'b0;
          op_next = req_op_i;
          lanes_next = lanes_i;
          left_next = (req_count_i == 7'h0 || req_count_i > 7'(PAGE_WORDS)) ? 7'h1 : req_count_i;
          pins_next.id_access_hv = (req_op_i == OP_ID_READ || req_op_i == OP_ID_WRITE);
          cmd_next = 3'h0;
          cmd_last_next = (req_op_i == OP_UNPROTECT) ? 3'h5 : 3'h2;
          tload = 1'b1;
          tval = cyc(ERS_SH_CYC);
          case (req_op_i)
            OP_PROT_WRITE, OP_UNPROTECT: state_next = S_CMD_SETUP;
            OP_ERASE: begin
              pins_next.out_gate_hv = 1'b1;
              state_next = S_ERS_SETUP;
            end
            OP_READ, OP_ID_READ: state_next = S_WAIT_WORD;
            default: state_next = S_WAIT_WORD;
          endcase
        end
      end
      S_CMD_SETUP: begin
        addr_next = cmd_w.addr;
        dq_next = cmd_w.data;
        dq_oe_next = 1'b1;
        pins_next.lane_select_n = ~lanes_reg;
        pins_next.lane_write_strobe_n = ~lanes_reg;
        tload = 1'b1;
        tval = cyc(WP_CYC);
        state_next = S_CMD_LOW;
      end
      S_CMD_LOW: if (tdone) begin
        pins_next.lane_write_strobe_n = '1;
        tload = 1'b1;
        tval = cyc(WPH_CYC > AH_CYC ? WPH_CYC : AH_CYC);
        state_next = S_CMD_HIGH;
      end
      S_CMD_HIGH: if (tdone) begin
        if (cmd_reg == cmd_last_reg) begin
          // Last command load: disable sequence waits a write cycle in S_PROGRAM, protected write goes on to its words
          state_next = (op_reg == OP_UNPROTECT) ? S_PROGRAM : S_WAIT_WORD;
          tload = (op_reg == OP_UNPROTECT);
          tval = cyc(WRITE_CYCLES);
          pins_next.lane_select_n = (op_reg == OP_UNPROTECT) ? '1 : pins_reg.lane_select_n;
          dq_oe_next = (op_reg != OP_UNPROTECT);
        end else begin
          cmd_next = cmd_reg + 3'h1;
          state_next = S_CMD_SETUP;
        end
      end
      S_WAIT_WORD: begin
        wready_next = word_valid_i && !wready_reg;
        if (word_valid_i && !wready_reg) begin
          addr_next = word_i.addr;
          dq_next = word_i.data;
          pins_next.lane_select_n = ~lanes_reg;
          tload = 1'b1;
          tval = cyc(WP_CYC);
          if (op_reg == OP_READ || op_reg == OP_ID_READ) begin
            dq_oe_next = 1'b0;
            pins_next.out_gate_n = 1'b0;
            state_next = S_RD_LOW;
          end else begin
            dq_oe_next = 1'b1;
            pins_next.out_gate_n = 1'b1;
            pins_next.lane_write_strobe_n = ~lanes_reg;
            state_next = S_DAT_LOW;
          end
        end
      end
      S_DAT_LOW: if (tdone) begin
        pins_next.lane_write_strobe_n = '1;
        left_next = left_reg - 7'h1;
        tload = 1'b1;
        tval = cyc(WPH_CYC > AH_CYC ? WPH_CYC : AH_CYC);
        state_next = S_DAT_HIGH;
      end
      S_DAT_HIGH: if (tdone) begin
        // Next load waits in S_WAIT_WORD for word_valid_i; nothing times the load window
        if (left_reg != 7'h0) begin
          state_next = S_WAIT_WORD;
        end else begin
          pins_next.lane_select_n = '1;
          dq_oe_next = 1'b0;
          tload = 1'b1;
          tval = cyc(WRITE_CYCLES);
          state_next = S_PROGRAM;
        end
      end
      S_PROGRAM: if (tdone) state_next = S_IDLE;
      S_RD_LOW: if (tdone) begin
        rd_next = dq_s2_reg;
        rd_valid_next = 1'b1;
        pins_next.out_gate_n = 1'b1;
        pins_next.lane_select_n = '1;
        state_next = S_RD_SAMPLE;
      end
      S_RD_SAMPLE: state_next = S_IDLE;
      S_ERS_SETUP: if (tdone) begin
        pins_next.lane_select_n = ~lanes_reg;
        pins_next.lane_write_strobe_n = ~lanes_reg;
        tload = 1'b1;
        tval = cyc(ERASE_CYCLES);
        state_next = S_ERS_PULSE;
      end
      S_ERS_PULSE: if (tdone) begin
        pins_next.lane_select_n = '1;
        pins_next.lane_write_strobe_n = '1;
        tload = 1'b1;
        tval = cyc(ERS_SH_CYC);
        state_next = S_ERS_HOLD;
      end
      S_ERS_HOLD: if (tdone) begin
        pins_next.out_gate_hv = 1'b0;
        state_next = S_IDLE;
      end
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    dq_s1_reg <= dq_i;
    dq_s2_reg <= dq_s1_reg;
    if (reset_i) begin
      state_reg <= S_IDLE;
      op_reg <= OP_READ;
      lanes_reg <= '0;
      left_reg <= '0;
      cmd_reg <= '0;
      cmd_last_reg <= '0;
      addr_reg <= '0;
      dq_reg <= '0;
      dq_oe_reg <= 1'b0;
      rd_reg <= '0;
      rd_valid_reg <= 1'b0;
      ready_reg <= 1'b0;
      wready_reg <= 1'b0;
      pins_reg <= '{lane_select_n: '1, lane_write_strobe_n: '1, out_gate_n: 1'b1,
                    out_gate_hv: 1'b0, id_access_hv: 1'b0};
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      lanes_reg <= lanes_next;
      left_reg <= left_next;
      cmd_reg <= cmd_next;
      cmd_last_reg <= cmd_last_next;
      addr_reg <= addr_next;
      dq_reg <= dq_next;
      dq_oe_reg <= dq_oe_next;
      rd_reg <= rd_next;
      rd_valid_reg <= rd_valid_next;
      ready_reg <= ready_next;
      wready_reg <= wready_next;
      pins_reg <= pins_next;
    end
  end

  assign req_ready_o = ready_reg;
  assign word_ready_o = wready_reg;
  assign rd_valid_o = rd_valid_reg;
  assign rd_data_o = rd_reg;
  assign addr_o = addr_reg;
  assign dq_o = dq_reg;
  assign dq_oe_o = dq_oe_reg;
  assign pins_o = pins_reg;
endmodule

/* bench/eeprom_host_checker.sv */
// Purpose: pin-level checks on the EEPROM host controller
// Assumes: one clock domain, synchronous active-high reset
// Notes: lane 0 stands for every lane; the bench drives all lanes together
`timescale 1ns/1ps
module eeprom_host_checker
  import eeprom_host_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = eeprom_host_pkg::ERASE_CYC
) (
  input wire logic ref_clk_i, // clock
  input wire logic reset_i, // sync reset
  input wire logic req_valid_i, // request
  input wire logic req_ready_o, // idle
  input wire logic word_ready_o, // word taken
  input wire logic [eeprom_host_pkg::ADDR_W-1:0] addr_o, // address pins
  input wire logic [eeprom_host_pkg::DATA_W-1:0] dq_o, // data out
  input wire logic dq_oe_o, // data driven
  input wire eeprom_host_pkg::pins_t pins_o // control pins
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic [19:0] erase_len_reg;
  logic [19:0] erase_len_next;
  logic [7:0] word_cnt_reg;
  logic [7:0] word_cnt_next;
  logic [15:0] gap_reg;
  logic [15:0] gap_next;
  logic s0;
  assign s0 = pins_o.lane_write_strobe_n[0];
  always_comb begin
    erase_len_next = (pins_o.out_gate_hv && !s0) ? erase_len_reg + 20'h00001 : 20'h00000;
    word_cnt_next = (req_valid_i && req_ready_o) ? 8'h00 : word_cnt_reg + {7'h00, word_ready_o};
    // Cycles with strobe high inside one selected load sequence
    gap_next = (!s0 || pins_o.lane_select_n[0]) ? 16'h0000 : gap_reg + 16'h0001;
  end
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      erase_len_reg <= 20'h00000;
      word_cnt_reg <= 8'h00;
      gap_reg <= 16'h0000;
    end else begin
      erase_len_reg <= erase_len_next;
      word_cnt_reg <= word_cnt_next;
      gap_reg <= gap_next;
    end
  end
  property p_dir_excl; dq_oe_o |-> pins_o.out_gate_n; endproperty
  property p_strobe_sel;
    (pins_o.lane_write_strobe_n != 4'hf) |-> pins_o.out_gate_n && ((~pins_o.lane_write_strobe_n & pins_o.lane_select_n) == 4'h0);
  endproperty
  property p_id_stable; (pins_o.lane_select_n != 4'hf) |-> $stable(pins_o.id_access_hv); endproperty
  property p_erase_gate; pins_o.out_gate_hv |-> pins_o.out_gate_n && !dq_oe_o && !pins_o.id_access_hv; endproperty
  property p_erase_len; $rose(s0) && pins_o.out_gate_hv |-> 32'(erase_len_reg) >= ERASE_CYCLES; endproperty
  property p_pulse_low; $fell(s0) |-> !s0 [*4]; endproperty
  property p_pulse_high; $rose(s0) && !pins_o.out_gate_hv |-> s0 [*2]; endproperty
  property p_addr_hold; !$past(s0) && !pins_o.out_gate_hv |-> $stable(addr_o) && $stable(dq_o); endproperty
  property p_page_len; word_ready_o |-> word_cnt_reg < 8'h40; endproperty
  property p_load_gap;
    !pins_o.lane_select_n[0] && pins_o.out_gate_n && !pins_o.out_gate_hv |-> 32'(gap_reg) < BLC_CYC;
  endproperty
  a_dir_excl: assert property (p_dir_excl) else $error("data driven with output gate low");
  a_strobe_sel: assert property (p_strobe_sel) else $error("strobe outside select or gate");
  a_id_stable: assert property (p_id_stable) else $error("id flag moved while selected");
  a_erase_gate: assert property (p_erase_gate) else $error("erase flag with bad pins");
  a_erase_len: assert property (p_erase_len) else $error("erase pulse too short");
  a_pulse_low: assert property (p_pulse_low) else $error("strobe low too short");
  a_pulse_high: assert property (p_pulse_high) else $error("strobe high too short");
  a_addr_hold: assert property (p_addr_hold) else $error("address or data moved in load");
  a_page_len: assert property (p_page_len) else $error("more than a page of words");
  a_load_gap: assert property (p_load_gap) else $error("next load came too late");
  c_erase: cover property ($rose(pins_o.out_gate_hv));
  c_id: cover property ($rose(pins_o.id_access_hv));
  c_full_page: cover property (word_ready_o && word_cnt_reg == 8'h3f);
endmodule

bind eeprom_host eeprom_host_checker #(.ERASE_CYCLES(ERASE_CYCLES)) checker_inst (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
  .word_ready_o(word_ready_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .pins_o(pins_o)
);

/* bench/eeprom_model.sv */
// Purpose: behavioural EEPROM module as seen from its pins
// Assumes: all lanes move together; lane 0 decides the mode
// Notes: no reset input, so protection outlives host resets
`timescale 1ns/1ps
module eeprom_model
  import eeprom_host_pkg::*;
#(
  parameter logic [eeprom_host_pkg::ADDR_W-1:0] ADDR_A = 15'h5555,
  parameter logic [eeprom_host_pkg::ADDR_W-1:0] ADDR_B = 15'h2aaa,
  parameter int GAP = 30 // Idle cycles that end a page, short for sim
) (
  input wire logic ref_clk_i, // clock
  input wire eeprom_host_pkg::pins_t pins_i, // control pins
  input wire logic [eeprom_host_pkg::ADDR_W-1:0] addr_i, // address pins
  input wire logic [eeprom_host_pkg::DATA_W-1:0] wdata_i, // data from host
  output logic [eeprom_host_pkg::DATA_W-1:0] rdata_o // data to host
);
  logic [DATA_W-1:0] mem [logic [ADDR_W:0]];
  logic [ADDR_W:0] ka [$];
  logic [DATA_W-1:0] kd [$];
  logic prot = 1'b0;
  logic was_wr = 1'b0;
  logic [DATA_W-1:0] held = '0;
  int idle = 0;
  int s = 0;
  wire wr = !pins_i.lane_write_strobe_n[0] && !pins_i.lane_select_n[0];
  function automatic bit cmd(input int i, input logic [ADDR_W-1:0] a, input logic [7:0] b);
    return ka[i][ADDR_W-1:0] === a && kd[i] === {4{b}};
  endfunction
  // Negedge sampling keeps clear of the host's launching edge
  always @(negedge ref_clk_i) begin
    s = 0;
    idle = idle + 1;
    if (wr && pins_i.out_gate_hv) begin
      mem.delete();
    end else if (!wr && was_wr && pins_i.out_gate_n && !pins_i.out_gate_hv) begin
      ka.push_back({pins_i.id_access_hv, addr_i});
      kd.push_back(wdata_i);
      idle = 0;
    end else if (idle == GAP && ka.size() > 0) begin
      if (ka.size() == 6 && cmd(0, ADDR_A, 8'haa) && cmd(1, ADDR_B, 8'h55) && cmd(2, ADDR_A, 8'h80)
          && cmd(3, ADDR_A, 8'haa) && cmd(4, ADDR_B, 8'h55) && cmd(5, ADDR_A, 8'h20)) begin
        prot = 1'b0;
        s = 6;
      end else if (ka.size() > 3 && cmd(0, ADDR_A, 8'haa) && cmd(1, ADDR_B, 8'h55) && cmd(2, ADDR_A, 8'ha0)) begin
        prot = 1'b1;
        s = 3;
      end else if (prot) begin
        s = ka.size();
      end
      for (int i = s; i < ka.size(); i++) begin
        mem[ka[i]] = kd[i];
      end
      ka.delete();
      kd.delete();
    end
    was_wr = wr;
    if (!pins_i.out_gate_n && pins_i.lane_write_strobe_n[0] && !pins_i.lane_select_n[0]) begin
      held = mem.exists({pins_i.id_access_hv, addr_i}) ? mem[{pins_i.id_access_hv, addr_i}] : '1;
    end else begin
      held = ~held; // A floating bus must not repeat the last read
    end
    rdata_o <= held;
  end
endmodule

/* bench/test_eeprom_host.sv */
// Purpose: self-checking bench for the EEPROM host controller
// Assumes: all four lanes active; write and erase waits shortened to 50
// Notes: the model keeps protection across host resets, as the part would
`timescale 1ns/1ps
module test_eeprom_host;
  import eeprom_host_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic req_valid_i = 1'b0;
  op_t req_op_i = OP_READ;
  logic [LANES-1:0] lanes_i = 4'hf;
  logic [6:0] req_count_i = 7'h01;
  logic word_valid_i = 1'b0;
  word_t word_i = '0;
  logic req_ready_o, word_ready_o, rd_valid_o, dq_oe_o;
  logic [DATA_W-1:0] rd_data_o, dq_o, dq_i;
  logic [ADDR_W-1:0] addr_o;
  pins_t pins_o;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  eeprom_host #(.ERASE_CYCLES(50), .WRITE_CYCLES(50)) dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i), .req_op_i(req_op_i),
    .lanes_i(lanes_i), .req_count_i(req_count_i), .req_ready_o(req_ready_o), .word_valid_i(word_valid_i),
    .word_i(word_i), .word_ready_o(word_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dq_i), .pins_o(pins_o)
  );
  eeprom_model model (.ref_clk_i(ref_clk_i), .pins_i(pins_o), .addr_i(addr_o), .wdata_i(dq_o), .rdata_o(dq_i));
  task automatic close_out();
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(input word_t w);
    @(posedge ref_clk_i);
    word_i <= w;
    word_valid_i <= 1'b1;
    do @(negedge ref_clk_i); while (word_ready_o !== 1'b1);
    @(posedge ref_clk_i);
    word_valid_i <= 1'b0;
  endtask
  task automatic op(input op_t o, input logic [6:0] n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    req_op_i <= o;
    req_count_i <= n;
    req_valid_i <= 1'b1;
    do @(negedge ref_clk_i); while (req_ready_o !== 1'b1);
    @(posedge ref_clk_i);
    req_valid_i <= 1'b0;
    if (o inside {OP_WRITE, OP_PROT_WRITE, OP_ID_WRITE})
      for (int i = 0; i < n; i++) put('{addr: a + ADDR_W'(i), data: d + DATA_W'(i)});
  endtask
  task automatic rd(input op_t o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    op(o, 7'h01, a, '0);
    put('{addr: a, data: '0});
    do @(negedge ref_clk_i); while (rd_valid_o !== 1'b1);
    check(rd_data_o, exp);
  endtask
  task automatic t_plain();
    op(OP_WRITE, 7'h02, 15'h0100, 32'h1234_5670);
    rd(OP_READ, 15'h0100, 32'h1234_5670);
    rd(OP_READ, 15'h0101, 32'h1234_5671);
  endtask
  task automatic t_protect();
    op(OP_PROT_WRITE, 7'h01, 15'h0200, 32'hcafe_0001);
    rd(OP_READ, 15'h0200, 32'hcafe_0001);
    rd(OP_READ, 15'h5555, 32'hffff_ffff);
    op(OP_WRITE, 7'h01, 15'h0200, 32'h0bad_0bad);
    rd(OP_READ, 15'h0200, 32'hcafe_0001);
    op(OP_PROT_WRITE, 7'h40, 15'h0300, 32'h5a00_0000);
    rd(OP_READ, 15'h033f, 32'h5a00_003f);
  endtask
  task automatic t_power();
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    op(OP_WRITE, 7'h01, 15'h0300, 32'h0);
    rd(OP_READ, 15'h0300, 32'h5a00_0000);
  endtask
  task automatic t_erase();
    op(OP_ERASE, 7'h01, 15'h0000, 32'h0);
    rd(OP_READ, 15'h0200, 32'hffff_ffff);
  endtask
  task automatic t_unprotect();
    op(OP_UNPROTECT, 7'h01, 15'h0000, 32'h0);
    op(OP_WRITE, 7'h01, 15'h0100, 32'h0000_abcd);
    rd(OP_READ, 15'h0100, 32'h0000_abcd);
  endtask
  task automatic t_ident();
    op(OP_ID_WRITE, 7'h01, 15'h7fc0, 32'h0000_0011);
    rd(OP_ID_READ, 15'h7fc0, 32'h0000_0011);
    op(OP_ID_WRITE, 7'h01, 15'h7fc0, 32'h0000_0022);
    rd(OP_ID_READ, 15'h7fc0, 32'h0000_0022);
    rd(OP_READ, 15'h7fc0, 32'hffff_ffff);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_plain();
    t_protect();
    t_power();
    t_erase();
    t_unprotect();
    t_ident();
    close_out();
  end
endmodule
